/* File: cse_pkg.sv */
// Purpose: Shared types and constants of the stack, bit and string executor
// Assumes: One state of execution is one clock period
// Notes:   Counts are in states; totals are built from these in the executor
package cse_pkg;
    // ****************************************
    // Widths and timing
    // ****************************************
    localparam int TW = 20;
    localparam int T_ONE = 1;
    localparam int T_BANK_SLOW = 2;
    localparam int T_PSH_NONE = 8;
    localparam int T_PSH_BASE = 29;
    localparam int T_PSH_LAST = 3;
    localparam int T_POP_NONE = 7;
    localparam int T_POP_BASE = 7;
    localparam int T_POP_PER = 3;
    localparam int T_POP_LAST = 2;
    localparam int T_BIT_RMW = 7;
    localparam int T_BR_MEM = 7;
    localparam int T_BR_IO = 6;
    localparam int T_TSB = 9;
    localparam int T_WAIT = 2;
    localparam int T_SWAP = 3;
    localparam int T_WEXCH = 2;
    localparam int T_SIGN_WIDEN_WORD = 2;
    localparam int T_STR_NONE = 5;
    localparam int T_STR_PRO = 4;
    localparam int T_CPY_PER = 8;
    localparam int T_SRC_PER = 7;
    localparam int T_FIL_PRO = 6;
    localparam int T_FIL_PER = 6;
    localparam int T_SRC_HIT = 1;
    // ****************************************
    // Field codes
    // ****************************************
    localparam logic [1:0] MD_DIR = 2'h0;
    localparam logic [1:0] MD_ABS = 2'h1;
    localparam logic [1:0] MD_IO = 2'h2;
    localparam logic [2:0] BK_PROG = 3'h0;
    localparam logic [2:0] BK_DATA = 3'h1;
    localparam logic [2:0] BK_EXTRA = 3'h2;
    localparam logic [2:0] BK_SYS = 3'h3;
    localparam logic [2:0] BK_USR = 3'h4;
    localparam logic [2:0] BK_STK = 3'h5;
    localparam logic [2:0] BK_DP = 3'h6;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_PFX_AD = 5'h01, OP_PFX_DT = 5'h02, OP_PFX_PC = 5'h03,
        OP_PFX_SP = 5'h04, OP_PFX_NOF = 5'h05, OP_BANK = 5'h06, OP_PUSH = 5'h07,
        OP_POP = 5'h08, OP_BIT_HIGH = 5'h09, OP_BIT_LOW = 5'h0a, OP_BR_LOW = 5'h0b,
        OP_BR_HIGH = 5'h0c, OP_TSB = 5'h0d, OP_WAIT_HIGH = 5'h0e, OP_WAIT_LOW = 5'h0f,
        OP_SWAP = 5'h10, OP_WEXCH = 5'h11, OP_SIGN_B = 5'h12, OP_SIGN_W = 5'h13,
        OP_ZERO_B = 5'h14, OP_ZERO_W = 5'h15, OP_COPY = 5'h16, OP_SEARCH = 5'h17,
        OP_FILL = 5'h18, OP_LD_REG = 5'h19, OP_LD_ACC = 5'h1a, OP_LD_SP = 5'h1b
    } cse_op_e;
    typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} cse_st_e;
    typedef struct packed {
        cse_op_e op;
        logic [7:0] lst;
        logic [2:0] bsel;
        logic [2:0] bpos;
        logic [1:0] mode;
        logic [15:0] addr;
        logic word;
        logic down;
    } cse_cmd_s;
    typedef struct packed {
        logic [7:0] prog, data, extra, sys, usr, stk, dp;
    } cse_bank_s;
    typedef struct packed {
        logic n, z, v, c;
    } cse_flags_s;
    typedef struct packed {
        logic req, we, word, io;
        logic [2:0] space;
        logic [15:0] addr;
        logic [15:0] wdata;
    } cse_mem_s;
    typedef struct packed {
        cse_st_e st;
        cse_cmd_s cmd;
        logic [TW-1:0] ph, tot;
        logic [2:0] sub, cur;
        logic [7:0] pend;
        logic hit, brn, done, nof;
        logic [2:0] space;
        logic [31:0] a;
        logic [15:0] sp;
        logic [7:0][15:0] rf;
        cse_flags_s fl;
        cse_mem_s mem;
    } cse_state_s;
endpackage

/* File: cse_exec.sv */
// Purpose: Executor for stack list, bank, prefix, bit, accumulator and string ops
// Assumes: Memory returns read data in the state its request stands
// Notes:   One command at a time; o_done marks the last state of each
// How it works
// - Bank to A: one state, data bank and direct page take two.
// - List push: 8 when empty, else 29 + count - 3 x last pushed.
// - One register and one word access per listed register; SP moves two each.
// - Prefixes redirect next access space or hold flags (search still sets NZVC); each takes one state.
// - Force bit high by byte read-modify-write, seven states, flags kept.
// - Force bit low by byte read-modify-write, seven states, flags kept.
// - Test and set branches on one, always writes one; 10 or 9 states.
// - Wait ops re-read the direct, absolute or I/O bit until it matches, unbounded.
// - Byte swap, word exchange, sign and zero widening; widening sets N and Z.
// - String copy moves from lower-word pointer to upper-word pointer, count in R0.
// - Search compares against lower word, sets NZVC, stops on match or count-out.
// - Fill writes lower word upward, sets N and Z, takes 6m + 6.
`timescale 1ns/10ps
module cse_exec (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Command
    input wire logic i_start,
    input wire cse_pkg::cse_cmd_s i_cmd,
    input wire cse_pkg::cse_bank_s i_banks,
    // Memory return
    input wire logic [15:0] i_mem_rdata,
    // Memory request
    output cse_pkg::cse_mem_s o_mem,
    // Status
    output logic o_busy,
    output logic o_done,
    output logic o_branch,
    output cse_pkg::cse_flags_s o_flags,
    output logic [31:0] o_acc,
    output logic [15:0] o_sp,
    output logic [15:0] o_count
);
    import cse_pkg::*;

    cse_state_s st_ff;
    cse_state_s nxt_st;
    logic go;

    assign go = i_start && (st_ff.st == ST_IDLE);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [3:0] f_cnt(input logic [7:0] l);
        logic [3:0] c;
        c = '0;
        for (int i = 0; i < 8; i++) begin
            c = c + 4'(l[i]);
        end
        return c;
    endfunction

    function automatic logic [2:0] f_lo(input logic [7:0] l);
        logic [2:0] r;
        r = '0;
        for (int i = 7; i >= 0; i--) begin
            if (l[i]) r = 3'(i);
        end
        return r;
    endfunction

    function automatic logic [2:0] f_hi(input logic [7:0] l);
        logic [2:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            if (l[i]) r = 3'(i);
        end
        return r;
    endfunction

    function automatic logic [15:0] f_step(input logic w, input logic d, input logic [15:0] p);
        logic [15:0] s;
        s = w ? 16'h0002 : 16'h0001;
        return d ? p - s : p + s;
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic b;
        logic [15:0] el, av;
        logic [16:0] dif;
        logic [7:0] bk;
        logic [2:0] r;
        int mi, pro, per;
        cse_op_e op;
        b = 1'b0;
        el = '0;
        av = '0;
        dif = '0;
        bk = '0;
        r = '0;
        op = go ? i_cmd.op : st_ff.cmd.op;
        pro = (op == OP_FILL) ? T_FIL_PRO : T_STR_PRO;
        per = (op == OP_FILL) ? T_FIL_PER : (op == OP_COPY) ? T_CPY_PER : T_SRC_PER;
        mi = st_ff.cmd.word ? 15 : 7;
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.mem.req = 1'b0;
        nxt_st.mem.we = 1'b0;
        if (go) begin
            nxt_st.cmd = i_cmd;
            nxt_st.st = ST_RUN;
            nxt_st.ph = '0;
            nxt_st.sub = '0;
            nxt_st.hit = 1'b0;
            nxt_st.brn = 1'b0;
            nxt_st.pend = i_cmd.lst;
            nxt_st.tot = TW'(T_ONE);
            nxt_st.mem.word = 1'b1;
            nxt_st.mem.io = 1'b0;
            nxt_st.mem.space = st_ff.space;
            unique case (i_cmd.op)
                OP_PFX_AD, OP_PFX_DT, OP_PFX_PC, OP_PFX_SP: begin
                    nxt_st.space = i_cmd.op[2:0];
                end
                OP_PFX_NOF: begin
                    nxt_st.nof = 1'b1;
                end
                OP_BANK: begin
                    unique case (i_cmd.bsel)
                        BK_PROG: bk = i_banks.prog;
                        BK_DATA: bk = i_banks.data;
                        BK_EXTRA: bk = i_banks.extra;
                        BK_SYS: bk = i_banks.sys;
                        BK_USR: bk = i_banks.usr;
                        BK_STK: bk = i_banks.stk;
                        BK_DP: bk = i_banks.dp;
                        default: bk = '0;
                    endcase
                    if (i_cmd.bsel == BK_DATA || i_cmd.bsel == BK_DP) begin
                        nxt_st.tot = TW'(T_BANK_SLOW);
                    end
                    nxt_st.a = {st_ff.a[15:0], 8'h00, bk};
                    if (!st_ff.nof) begin
                        nxt_st.fl.n = 1'b0;
                        nxt_st.fl.z = (bk == 8'h00);
                    end
                end
                OP_PUSH: begin
                    nxt_st.tot = (i_cmd.lst == 8'h00) ? TW'(T_PSH_NONE) :
                        TW'(T_PSH_BASE + int'(f_cnt(i_cmd.lst)) - T_PSH_LAST * int'(f_lo(i_cmd.lst)));
                end
                OP_POP: begin
                    nxt_st.tot = (i_cmd.lst == 8'h00) ? TW'(T_POP_NONE) :
                        TW'(T_POP_BASE + T_POP_PER * int'(f_cnt(i_cmd.lst))
                        + T_POP_LAST * int'(f_hi(i_cmd.lst)));
                end
                OP_BIT_HIGH, OP_BIT_LOW, OP_BR_LOW, OP_BR_HIGH, OP_TSB, OP_WAIT_HIGH, OP_WAIT_LOW: begin
                    nxt_st.mem.req = 1'b1;
                    nxt_st.mem.word = 1'b0;
                    nxt_st.mem.io = (i_cmd.mode == MD_IO);
                    unique case (i_cmd.mode)
                        MD_DIR: nxt_st.mem.addr = {i_banks.dp, i_cmd.addr[7:0]};
                        MD_IO: nxt_st.mem.addr = {8'h00, i_cmd.addr[7:0]};
                        default: nxt_st.mem.addr = i_cmd.addr;
                    endcase
                    if (i_cmd.op == OP_BIT_HIGH || i_cmd.op == OP_BIT_LOW) begin
                        nxt_st.tot = TW'(T_BIT_RMW);
                    end else if (i_cmd.op == OP_TSB) begin
                        nxt_st.tot = TW'(T_TSB);
                    end else if (i_cmd.op == OP_WAIT_HIGH || i_cmd.op == OP_WAIT_LOW) begin
                        nxt_st.tot = TW'(T_WAIT);
                    end else begin
                        nxt_st.tot = (i_cmd.mode == MD_IO) ? TW'(T_BR_IO) : TW'(T_BR_MEM);
                    end
                end
                OP_SWAP: begin
                    nxt_st.tot = TW'(T_SWAP);
                    nxt_st.a[15:0] = {st_ff.a[7:0], st_ff.a[15:8]};
                end
                OP_WEXCH: begin
                    nxt_st.tot = TW'(T_WEXCH);
                    nxt_st.a = {st_ff.a[15:0], st_ff.a[31:16]};
                end
                OP_SIGN_B, OP_ZERO_B: begin
                    av = {(i_cmd.op == OP_SIGN_B) ? {8{st_ff.a[7]}} : 8'h00, st_ff.a[7:0]};
                    nxt_st.a[15:0] = av;
                    if (!st_ff.nof) begin
                        nxt_st.fl.n = av[15];
                        nxt_st.fl.z = (av == 16'h0000);
                    end
                end
                OP_SIGN_W, OP_ZERO_W: begin
                    if (i_cmd.op == OP_SIGN_W) begin
                        nxt_st.tot = TW'(T_SIGN_WIDEN_WORD);
                    end
                    nxt_st.a[31:16] = (i_cmd.op == OP_SIGN_W) ? {16{st_ff.a[15]}} : 16'h0000;
                    if (!st_ff.nof) begin
                        nxt_st.fl.n = (i_cmd.op == OP_SIGN_W) && st_ff.a[15];
                        nxt_st.fl.z = (st_ff.a[15:0] == 16'h0000);
                    end
                end
                OP_COPY: begin
                    nxt_st.mem.word = i_cmd.word;
                    nxt_st.tot = (st_ff.rf[0] == 16'h0000) ? TW'(T_STR_NONE) :
                        TW'(T_STR_PRO + T_CPY_PER * int'(st_ff.rf[0]));
                end
                OP_SEARCH: begin
                    nxt_st.mem.word = i_cmd.word;
                    nxt_st.tot = (st_ff.rf[0] == 16'h0000) ? TW'(T_STR_NONE) :
                        TW'(T_STR_PRO + T_SRC_PER * int'(st_ff.rf[0]));
                end
                OP_FILL: begin
                    nxt_st.mem.word = i_cmd.word;
                    nxt_st.tot = TW'(T_FIL_PRO + T_FIL_PER * int'(st_ff.rf[0]));
                    av = i_cmd.word ? st_ff.a[15:0] : {8'h00, st_ff.a[7:0]};
                    if (!st_ff.nof) begin
                        nxt_st.fl.n = i_cmd.word ? av[15] : av[7];
                        nxt_st.fl.z = (av == 16'h0000);
                    end
                end
                OP_LD_REG: nxt_st.rf[i_cmd.bsel] = i_cmd.addr;
                OP_LD_ACC: nxt_st.a = {st_ff.a[15:0], i_cmd.addr};
                OP_LD_SP: nxt_st.sp = i_cmd.addr;
                default: ;
            endcase
        end else if (st_ff.st == ST_RUN) begin
            nxt_st.ph = st_ff.ph + TW'(1);
            if (nxt_st.ph <= TW'(pro) || st_ff.sub == 3'(per - 1)) begin
                nxt_st.sub = '0;
            end else begin
                nxt_st.sub = st_ff.sub + 3'h1;
            end
            b = i_mem_rdata[st_ff.cmd.bpos];
            unique case (st_ff.cmd.op)
                OP_POP: begin
                    if (st_ff.mem.req) nxt_st.rf[st_ff.cur] = i_mem_rdata;
                end
                OP_BIT_HIGH, OP_BIT_LOW, OP_TSB: begin
                    if (st_ff.ph == '0) begin
                        el = {8'h00, i_mem_rdata[7:0]};
                        el[st_ff.cmd.bpos] = (st_ff.cmd.op != OP_BIT_LOW);
                        nxt_st.mem.req = 1'b1;
                        nxt_st.mem.we = 1'b1;
                        nxt_st.mem.wdata = el;
                        if (st_ff.cmd.op == OP_TSB) begin
                            nxt_st.brn = b;
                            nxt_st.tot = st_ff.tot + TW'(b);
                            if (!st_ff.nof) nxt_st.fl.z = !b;
                        end
                    end
                end
                OP_BR_LOW, OP_BR_HIGH: begin
                    if (st_ff.ph == '0) begin
                        nxt_st.brn = (b == (st_ff.cmd.op == OP_BR_HIGH));
                        nxt_st.tot = st_ff.tot + TW'(nxt_st.brn);
                        if (!st_ff.nof) nxt_st.fl.z = !b;
                    end
                end
                OP_WAIT_HIGH, OP_WAIT_LOW: begin
                    if (st_ff.ph == '0 && b != (st_ff.cmd.op == OP_WAIT_HIGH)) begin
                        nxt_st.ph = '0;
                        nxt_st.mem.req = 1'b1;
                    end
                end
                OP_COPY: begin
                    if (st_ff.mem.req && !st_ff.mem.we) begin
                        nxt_st.mem.req = 1'b1;
                        nxt_st.mem.we = 1'b1;
                        nxt_st.mem.addr = st_ff.a[31:16];
                        nxt_st.mem.wdata = st_ff.cmd.word ? i_mem_rdata : {8'h00, i_mem_rdata[7:0]};
                        nxt_st.a[31:16] = f_step(st_ff.cmd.word, st_ff.cmd.down, st_ff.a[31:16]);
                        nxt_st.a[15:0] = f_step(st_ff.cmd.word, st_ff.cmd.down, st_ff.a[15:0]);
                        nxt_st.rf[0] = st_ff.rf[0] - 16'h0001;
                    end
                end
                OP_SEARCH: begin
                    if (st_ff.mem.req) begin
                        el = st_ff.cmd.word ? i_mem_rdata : {8'h00, i_mem_rdata[7:0]};
                        av = st_ff.cmd.word ? st_ff.a[15:0] : {8'h00, st_ff.a[7:0]};
                        dif = {1'b0, el} - {1'b0, av};
                        nxt_st.fl.n = dif[mi];
                        nxt_st.fl.z = st_ff.cmd.word ? (dif[15:0] == 16'h0000) : (dif[7:0] == 8'h00);
                        nxt_st.fl.v = (el[mi] ^ av[mi]) & (el[mi] ^ dif[mi]);
                        nxt_st.fl.c = dif[mi + 1];
                        nxt_st.a[31:16] = f_step(st_ff.cmd.word, st_ff.cmd.down, st_ff.a[31:16]);
                        nxt_st.rf[0] = st_ff.rf[0] - 16'h0001;
                        if (nxt_st.fl.z) begin
                            nxt_st.hit = 1'b1;
                            nxt_st.tot = st_ff.tot - TW'(T_SRC_PER * int'(nxt_st.rf[0])) + TW'(T_SRC_HIT);
                        end
                    end
                end
                default: ;
            endcase
            if (nxt_st.ph == nxt_st.tot) begin
                nxt_st.st = ST_IDLE;
                if (st_ff.cmd.op < OP_PFX_AD || st_ff.cmd.op > OP_PFX_NOF) begin
                    nxt_st.space = '0;
                    nxt_st.nof = 1'b0;
                end
            end
        end
        // Stack and string element issue
        if (nxt_st.st == ST_RUN) begin
            if ((op == OP_PUSH || op == OP_POP) && nxt_st.pend != 8'h00) begin
                r = (op == OP_PUSH) ? f_hi(nxt_st.pend) : f_lo(nxt_st.pend);
                nxt_st.pend[r] = 1'b0;
                nxt_st.cur = r;
                nxt_st.mem.req = 1'b1;
                nxt_st.mem.word = 1'b1;
                if (op == OP_PUSH) begin
                    nxt_st.sp = nxt_st.sp - 16'h0002;
                    nxt_st.mem.we = 1'b1;
                    nxt_st.mem.addr = nxt_st.sp;
                    nxt_st.mem.wdata = nxt_st.rf[r];
                end else begin
                    nxt_st.mem.addr = nxt_st.sp;
                    nxt_st.sp = nxt_st.sp + 16'h0002;
                end
            end
            if ((op == OP_COPY || op == OP_SEARCH || op == OP_FILL) && nxt_st.ph >= TW'(pro)
                && nxt_st.sub == 3'h0 && nxt_st.rf[0] != 16'h0000 && !nxt_st.hit) begin
                nxt_st.mem.req = 1'b1;
                nxt_st.mem.addr = (op == OP_COPY) ? nxt_st.a[15:0] : nxt_st.a[31:16];
                if (op == OP_FILL) begin
                    nxt_st.mem.we = 1'b1;
                    nxt_st.mem.wdata = nxt_st.cmd.word ? nxt_st.a[15:0] : {8'h00, nxt_st.a[7:0]};
                    nxt_st.a[31:16] = f_step(nxt_st.cmd.word, 1'b0, nxt_st.a[31:16]);
                    nxt_st.rf[0] = nxt_st.rf[0] - 16'h0001;
                end
            end
        end
        nxt_st.done = (nxt_st.st == ST_RUN) && (nxt_st.ph + TW'(1) == nxt_st.tot);
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_mem = st_ff.mem;
    assign o_busy = (st_ff.st == ST_RUN);
    assign o_done = st_ff.done;
    assign o_branch = st_ff.brn;
    assign o_flags = st_ff.fl;
    assign o_acc = st_ff.a;
    assign o_sp = st_ff.sp;
    assign o_count = st_ff.rf[0];

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    property p_bank_slow;
        go && i_cmd.op == OP_BANK && (i_cmd.bsel == BK_DATA || i_cmd.bsel == BK_DP) |-> ##1 !o_done ##1 o_done;
    endproperty
    a_bank_slow: assert property (p_bank_slow) else $error("Slow bank move length wrong");
    property p_pfx;
        go && i_cmd.op >= OP_PFX_AD && i_cmd.op <= OP_PFX_NOF |-> ##1 o_done ##1 !o_busy;
    endproperty
    a_pfx: assert property (p_pfx) else $error("Prefix not one state");
    property p_set;
        go && i_cmd.op == OP_BIT_HIGH |-> ##1 (!o_done)[*6] ##1 o_done;
    endproperty
    a_set: assert property (p_set) else $error("Bit force high not seven states");
    property p_clr;
        o_mem.req && o_mem.we && st_ff.cmd.op == OP_BIT_LOW |-> !o_mem.wdata[st_ff.cmd.bpos] && o_flags == $past(o_flags);
    endproperty
    a_clr: assert property (p_clr) else $error("Bit force low wrote a one");
    property p_push_sp;
        o_mem.req && o_mem.we && st_ff.cmd.op == OP_PUSH |-> o_sp == $past(o_sp) - 16'h0002 && o_mem.addr == o_sp;
    endproperty
    a_push_sp: assert property (p_push_sp) else $error("Push pointer step wrong");
    property p_wexch;
        go && i_cmd.op == OP_WEXCH |=> o_acc == {$past(o_acc[15:0]), $past(o_acc[31:16])};
    endproperty
    a_wexch: assert property (p_wexch) else $error("Word exchange wrong");
    property p_cnt_dn;
        o_busy && st_ff.cmd.op >= OP_COPY && st_ff.cmd.op <= OP_FILL |=> o_count <= $past(o_count);
    endproperty
    a_cnt_dn: assert property (p_cnt_dn) else $error("String count rose");
    property p_fill_step;
        o_mem.req && st_ff.cmd.op == OP_FILL |-> st_ff.a[31:16] == o_mem.addr + (st_ff.cmd.word ? 16'h0002 : 16'h0001);
    endproperty
    a_fill_step: assert property (p_fill_step) else $error("Fill pointer step wrong");
    property p_copy_zero;
        go && i_cmd.op == OP_COPY && o_count == 16'h0000 |-> ##1 (!o_done)[*4] ##1 o_done;
    endproperty
    a_copy_zero: assert property (p_copy_zero) else $error("Empty copy not five states");
    c_push: cover property (go && i_cmd.op == OP_PUSH && i_cmd.lst != 8'h00);
    c_hit: cover property (st_ff.hit && o_done);
    c_wait: cover property (st_ff.cmd.op == OP_WAIT_HIGH && o_mem.req ##1 o_mem.req ##1 o_done);
endmodule

/* File: cse_mem_model.sv */
// Purpose: Behavioural memory and I/O space facing the executor
// Assumes: Reads answer in the cycle of the request
// Notes:   A released data bus shows the inverse of the last value read
`timescale 1ns/10ps
module cse_mem_model (
    // Clock
    input wire logic i_clock,
    // Request and answer
    input wire cse_pkg::cse_mem_s i_mem,
    output logic [15:0] o_rdata
);
    import cse_pkg::*;
    logic [15:0] mem [0:255];
    logic [15:0] last = 16'h0000;
    assign o_rdata = (i_mem.req && !i_mem.we) ? mem[i_mem.addr[7:0]] : ~last;
    always @(posedge i_clock) begin
        if (i_mem.req && i_mem.we) begin
            mem[i_mem.addr[7:0]] <= i_mem.wdata;
        end
        if (i_mem.req && !i_mem.we) begin
            last <= mem[i_mem.addr[7:0]];
        end
    end
endmodule

/* File: cse_exec_tb_top.sv */
// Purpose: Self-checking bench of the executor
// Assumes: Direct page is zero, so direct addresses are the low byte
// Notes:   State counts are measured from the taking edge to o_done
`timescale 1ns/10ps
module cse_exec_tb_top;
    import cse_pkg::*;
    logic i_clock = 1'b0, i_rst_n = 1'b0, i_start = 1'b0, busy, done, branch;
    cse_cmd_s i_cmd = '0;
    cse_bank_s i_banks = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h00};
    logic [15:0] rdata, sp, count;
    logic [31:0] acc;
    cse_mem_s mem;
    cse_flags_s flags, fl0;
    int err_count = 0, checks_done = 0, n;
    always #25 i_clock = ~i_clock;
    cse_exec DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_start(i_start), .i_cmd(i_cmd),
        .i_banks(i_banks), .i_mem_rdata(rdata), .o_mem(mem), .o_busy(busy), .o_done(done),
        .o_branch(branch), .o_flags(flags), .o_acc(acc), .o_sp(sp), .o_count(count));
    cse_mem_model u_mem (.i_clock(i_clock), .i_mem(mem), .o_rdata(rdata));
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic run(input cse_op_e op, input logic [7:0] l, input logic [2:0] s,
                       input logic [1:0] md, input logic [15:0] a);
        @(negedge i_clock);
        i_cmd = {op, l, s, 3'h2, md, a, 1'b0, 1'b0};
        i_start = 1'b1;
        @(negedge i_clock);
        i_start = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 400) begin
            @(negedge i_clock);
            n++;
        end
        if (n >= 400) begin
            chk(n, 0);
            finish_test();
        end
    endtask
    task automatic t_bank_pfx();
        for (int k = 0; k < 7; k++) begin
            run(OP_BANK, 8'h00, 3'(k), MD_DIR, 16'h0000);
            chk({n, acc[7:0]}, {(k == 1 || k == 6) ? 32'd2 : 32'd1, (k == 6) ? 8'h00 : 8'(17 * (k + 1))});
        end
        for (int k = 1; k < 6; k++) begin
            run(cse_op_e'(k), 8'h00, 3'h0, MD_DIR, 16'h0000);
            chk(n, 1);
        end
        $display("bank and prefix test ended");
    endtask
    task automatic t_stack();
        run(OP_LD_SP, 8'h00, 3'h0, MD_DIR, 16'h0080);
        run(OP_LD_REG, 8'h00, 3'h0, MD_DIR, 16'h1234);
        run(OP_PUSH, 8'h00, 3'h0, MD_DIR, 16'h0000);
        chk(n, 8);
        run(OP_PUSH, 8'h01, 3'h0, MD_DIR, 16'h0000);
        chk(n, 30);
        chk({sp, u_mem.mem[8'h7e]}, 32'h007e1234);
        run(OP_LD_REG, 8'h00, 3'h0, MD_DIR, 16'h0000);
        run(OP_POP, 8'h00, 3'h0, MD_DIR, 16'h0000);
        chk(n, 7);
        run(OP_POP, 8'h01, 3'h0, MD_DIR, 16'h0000);
        chk(n, 10);
        chk({sp, count}, 32'h00801234);
        $display("stack test ended");
    endtask
    task automatic t_bits();
        for (int k = 0; k < 3; k++) begin
            fl0 = flags;
            run(OP_BIT_HIGH, 8'h00, 3'h0, 2'(k), 16'h0040);
            chk({n, u_mem.mem[8'h40][7:0], flags}, {32'd7, 8'h04, fl0});
            run(OP_BIT_LOW, 8'h00, 3'h0, 2'(k), 16'h0040);
            chk({n, u_mem.mem[8'h40][7:0], flags}, {32'd7, 8'h00, fl0});
        end
        run(OP_BR_LOW, 8'h00, 3'h0, MD_DIR, 16'h0040);
        chk({n, branch, flags.z}, {32'd8, 2'b11});
        run(OP_BR_HIGH, 8'h00, 3'h0, MD_ABS, 16'h0040);
        chk({n, branch}, {32'd7, 1'b0});
        run(OP_BR_LOW, 8'h00, 3'h0, MD_IO, 16'h0040);
        chk(n, 7);
        run(OP_BR_HIGH, 8'h00, 3'h0, MD_IO, 16'h0040);
        chk(n, 6);
        run(OP_TSB, 8'h00, 3'h0, MD_ABS, 16'h0040);
        chk({n, u_mem.mem[8'h40][7:0]}, {32'd9, 8'h04});
        run(OP_TSB, 8'h00, 3'h0, MD_ABS, 16'h0040);
        chk({n, branch}, {32'd10, 1'b1});
        run(OP_PFX_DT, 8'h00, 3'h0, MD_DIR, 16'h0000);
        run(OP_BIT_HIGH, 8'h00, 3'h0, MD_ABS, 16'h0040);
        chk(mem.space, 3'h2);
        $display("bit test ended");
    endtask
    task automatic t_acc();
        run(OP_LD_ACC, 8'h00, 3'h0, MD_DIR, 16'h00f0);
        run(OP_LD_ACC, 8'h00, 3'h0, MD_DIR, 16'h8000);
        run(OP_SWAP, 8'h00, 3'h0, MD_DIR, 16'h0000);
        chk({n, acc}, {32'd3, 32'h00f00080});
        run(OP_WEXCH, 8'h00, 3'h0, MD_DIR, 16'h0000);
        chk({n, acc}, {32'd2, 32'h008000f0});
        run(OP_SIGN_B, 8'h00, 3'h0, MD_DIR, 16'h0000);
        chk({n, acc, flags.n, flags.z}, {32'd1, 32'h0080fff0, 2'b10});
        run(OP_SIGN_W, 8'h00, 3'h0, MD_DIR, 16'h0000);
        chk({n, acc, flags.n, flags.z}, {32'd2, 32'hfffffff0, 2'b10});
        run(OP_ZERO_B, 8'h00, 3'h0, MD_DIR, 16'h0000);
        run(OP_ZERO_W, 8'h00, 3'h0, MD_DIR, 16'h0000);
        chk({n, acc, flags.n, flags.z}, {32'd1, 32'h000000f0, 2'b00});
        run(OP_WAIT_HIGH, 8'h00, 3'h0, MD_IO, 16'h0040);
        chk(n, 2);
        $display("accumulator and wait test ended");
    endtask
    task automatic t_string();
        run(OP_LD_REG, 8'h00, 3'h0, MD_DIR, 16'h0000);
        run(OP_COPY, 8'h00, 3'h0, MD_DIR, 16'h0000);
        chk(n, 5);
        run(OP_LD_REG, 8'h00, 3'h0, MD_DIR, 16'h0001);
        run(OP_LD_ACC, 8'h00, 3'h0, MD_DIR, 16'h0060);
        run(OP_LD_ACC, 8'h00, 3'h0, MD_DIR, 16'h0050);
        run(OP_COPY, 8'h00, 3'h0, MD_DIR, 16'h0000);
        chk({n, u_mem.mem[8'h60][7:0]}, {32'd12, 8'ha5});
        chk({acc, count}, {32'h00610051, 16'h0000});
        run(OP_LD_REG, 8'h00, 3'h0, MD_DIR, 16'h0002);
        run(OP_FILL, 8'h00, 3'h0, MD_DIR, 16'h0000);
        chk({n, u_mem.mem[8'h62][7:0], count}, {32'd18, 8'h51, 16'h0000});
        run(OP_LD_REG, 8'h00, 3'h0, MD_DIR, 16'h0003);
        run(OP_LD_ACC, 8'h00, 3'h0, MD_DIR, 16'h0070);
        run(OP_LD_ACC, 8'h00, 3'h0, MD_DIR, 16'h0022);
        run(OP_SEARCH, 8'h00, 3'h0, MD_DIR, 16'h0000);
        chk({n, flags, count}, {32'd19, 4'h4, 16'h0001});
        $display("string test ended");
    endtask
    initial begin
        u_mem.mem[8'h40] = 16'h0000;
        u_mem.mem[8'h50] = 16'h00a5;
        u_mem.mem[8'h70] = 16'h0011;
        u_mem.mem[8'h71] = 16'h0022;
        repeat (2) @(negedge i_clock);
        i_rst_n = 1'b1;
        t_bank_pfx();
        t_stack();
        t_bits();
        t_acc();
        t_string();
        finish_test();
    end
endmodule
